// ===== design/lcd_shift.sv
// serial frame shift register, clocked by the host's serial clock
// assumes the host stops the serial clock while the latch strobe is high
`timescale 1ns/10ps
`include "lcd_regs.svh"
module lcd_shift import lcd_pkg::*; #(
  parameter int unsigned FRAME_BITS = `LCD_FRAME_BITS,
  parameter int unsigned KEEP_BITS = `LCD_KEEP_BITS
) (
  input wire logic serial_clk,
  input wire logic presetn,
  input wire logic serial_data,
  output logic [KEEP_BITS-1:0] frame_word
);

  if (KEEP_BITS < 1 || KEEP_BITS > FRAME_BITS) begin : g_bad_keep
    $error("lcd_shift keep width must lie within the frame");
  end

  logic [FRAME_BITS-1:0] frame_reg;

  // first bit shifted ends at the top; sampled on the rising serial clock
  always_ff @(posedge serial_clk or negedge presetn) begin
    if (!presetn) begin
      frame_reg <= '0;
    end else begin
      frame_reg <= {frame_reg[FRAME_BITS-2:0], serial_data}; // [R2] [R13]
    end
  end

  // the trailing dummy positions never leave this module
  assign frame_word = frame_reg[FRAME_BITS-1 -: KEEP_BITS]; // [R7] [R12]

  property p_shift_one;
    @(posedge serial_clk) disable iff (!presetn)
    1'b1 |=> frame_reg == {$past(frame_reg[FRAME_BITS-2:0]), $past(serial_data)};
  endproperty
  a_shift_one: assert property (p_shift_one) else $error("shift register lost a bit"); // [R2]

endmodule

// ===== design/lcd_sync.sv
// two flip-flop level synchroniser, one per bit
// assumes inputs from another clock domain or a pin
`timescale 1ns/10ps
module lcd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("lcd_sync width must be at least one");
  end

  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// ===== design/lcd_top.sv
// multiplexed lcd segment driver core: serial frame load, row latches, common scan,
// apb control and status
// assumes an apb3 master on pclk and a host that drives serial clock, data and strobe
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "lcd_regs.svh"
// Notes on behaviour
// R1 - host holds display off until first latch
// R2 - each serial bit shifts into 88-bit register
// R3 - strobe high copies segment bits to latches
// R4 - 80 segments follow latch of scanned line
// R5 - select bit k targets row latch k
// R6 - several select bits write every chosen latch
// R7 - dummy frame bits are ignored
// R8 - three, four or five common lines scanned
// R9 - each common slot spans sixteen oscillator ticks
// R10 - active common high then low, others mid
// R11 - segment level from latch bit and phase
// R12 - frame is data, select, then dummy bits
// R13 - rising serial clock samples; strobe low shifting
module lcd_top import lcd_pkg::*; #(
  parameter int unsigned OSC_DIV_RESET = `LCD_OSC_DIV_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`LCD_ADDR_BITS-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe,
  input wire logic display_off_n,
  output logic [2*`LCD_SEL_BITS-1:0] common_level,
  output logic [2*`LCD_SEG_BITS-1:0] segment_level
);

  localparam int unsigned SEGS = `LCD_SEG_BITS;
  localparam int unsigned LINES = `LCD_SEL_BITS;
  localparam logic [15:0] OSC_DIV_INIT = OSC_DIV_RESET[15:0];
  localparam logic [3:0] LAST_TICK = 4'(`LCD_SLOT_TICKS - 1);
  localparam logic [3:0] HALF_LAST = 4'(`LCD_HALF_TICKS - 1);

  if (OSC_DIV_RESET < `LCD_OSC_DIV_MIN || OSC_DIV_RESET > 65535) begin : g_bad_div
    $error("lcd_top oscillator divider out of range");
  end

  // link side: frame word is quasi-static while the strobe is high
  logic [`LCD_KEEP_BITS-1:0] frame_word;
  lcd_shift #(
    .FRAME_BITS(`LCD_FRAME_BITS),
    .KEEP_BITS(`LCD_KEEP_BITS)
  ) u_shift (
    .serial_clk(serial_clk),
    .presetn(presetn),
    .serial_data(serial_data),
    .frame_word(frame_word)
  );

  // strobe and display-off pins enter the pclk domain
  logic [1:0] pin_sync;
  lcd_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({display_off_n, latch_strobe}),
    .sync_out(pin_sync)
  );

  wire strobe_level = pin_sync[0];
  wire display_on = pin_sync[1];

  // frame fields: data first, select after it
  wire [SEGS-1:0] seg_word = frame_word[`LCD_KEEP_BITS-1 -: SEGS]; // [R12]
  logic [LINES-1:0] select_mask;
  for (genvar k = 0; k < LINES; k++) begin : g_sel
    assign select_mask[k] = frame_word[LINES-1-k]; // [R5]
  end

  // row latches, one per common line; the strobe gates the copy because the
  // serial clock is stopped then, so the word cannot move mid-capture
  logic [SEGS-1:0] row_latch [LINES];
  for (genvar k = 0; k < LINES; k++) begin : g_row
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        row_latch[k] <= '0;
      end else if (strobe_level && select_mask[k]) begin
        row_latch[k] <= seg_word; // [R3] [R5] [R6]
      end
    end
  end

  // apb decode
  logic [1:0] duty_sel;
  logic [15:0] osc_div;
  logic [2:0] slot;
  lcd_phase_t phase;
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire hit_ctrl = paddr == `LCD_CTRL_OFS;
  wire hit_status = paddr == `LCD_STATUS_OFS;
  wire hit_oscdiv = paddr == `LCD_OSCDIV_OFS;
  wire addr_ok = hit_ctrl | hit_status | hit_oscdiv;
  // reserved duty code and too small a divider are refused silently
  wire duty_ok = pwdata[`LCD_CTRL_DUTY_LSB +: 2] != 2'b11;
  wire div_ok = pwdata[15:0] >= 16'(`LCD_OSC_DIV_MIN);
  wire wr_ctrl = apb_done & pwrite & hit_ctrl & duty_ok;
  wire wr_oscdiv = apb_done & pwrite & hit_oscdiv & div_ok;

  wire [31:0] status_word = {26'h0, display_on, strobe_level, phase, slot};
  wire [31:0] read_word = hit_ctrl ? {30'h0, duty_sel} :
                          hit_status ? status_word :
                          hit_oscdiv ? {16'h0, osc_div} : 32'h0;

  // one wait-free access phase; answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      prdata <= (apb_setup & ~pwrite) ? read_word : 32'h0;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_sel <= `LCD_CTRL_DUTY_RST;
      osc_div <= OSC_DIV_INIT;
    end else begin
      if (wr_ctrl) begin
        duty_sel <= pwdata[`LCD_CTRL_DUTY_LSB +: 2]; // [R8]
      end
      if (wr_oscdiv) begin
        osc_div <= pwdata[15:0];
      end
    end
  end

  // oscillator timebase; compare with >= so a smaller divider never overruns
  logic [15:0] osc_cnt;
  logic [3:0] sub_cnt;
  wire osc_tick = osc_cnt >= osc_div - 16'h1;
  wire slot_end = osc_tick && sub_cnt == LAST_TICK; // [R9]
  wire half_end = osc_tick && sub_cnt == HALF_LAST;
  wire [15:0] next_osc_cnt = osc_tick ? 16'h0 : osc_cnt + 16'h1;
  wire [3:0] next_sub_cnt = osc_tick ? sub_cnt + 4'h1 : sub_cnt;

  // number of scanned lines from the duty selection
  wire [2:0] line_count = (duty_sel == lcd_duty_3) ? 3'h3 :
                          (duty_sel == lcd_duty_4) ? 3'h4 : 3'h5;
  wire [2:0] last_slot = line_count - 3'h1;
  wire [2:0] next_slot = slot_end ? ((slot >= last_slot) ? 3'h0 : slot + 3'h1) :
                         ((slot > last_slot) ? 3'h0 : slot); // [R8]

  // phase machine: full high for the first half slot, full low for the second
  lcd_phase_t next_phase;
  always_comb begin
    next_phase = phase;
    unique case (phase)
      lcd_ph_high: begin
        next_phase = half_end ? lcd_ph_low : lcd_ph_high; // [R10]
      end
      lcd_ph_low: begin
        next_phase = slot_end ? lcd_ph_high : lcd_ph_low; // [R10]
      end
    endcase
  end

  // scan state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= 16'h0;
      sub_cnt <= 4'h0;
      slot <= 3'h0;
      phase <= lcd_ph_high;
    end else begin
      osc_cnt <= next_osc_cnt;
      sub_cnt <= next_sub_cnt; // [R9]
      slot <= next_slot;
      phase <= next_phase;
    end
  end

  // latch of the line being scanned
  wire [SEGS-1:0] cur_row = (slot < 3'(LINES)) ? row_latch[slot] : '0;
  wire active_high = phase == lcd_ph_high;

  // common drive levels
  logic [2*LINES-1:0] next_common_level;
  always_comb begin
    next_common_level = '0;
    for (int k = 0; k < LINES; k++) begin
      if (slot == 3'(k)) begin
        next_common_level[2*k +: 2] = active_high ? lcd_lvl_high : lcd_lvl_low; // [R10]
      end else begin
        next_common_level[2*k +: 2] = active_high ? lcd_lvl_lower_mid : lcd_lvl_upper_mid;
      end
    end
  end

  // segment drive levels; display off forces every bit to the unlit levels
  logic [2*SEGS-1:0] next_segment_level;
  always_comb begin
    next_segment_level = '0;
    for (int k = 0; k < SEGS; k++) begin
      if (cur_row[SEGS-1-k] && display_on) begin // [R1] [R4]
        next_segment_level[2*k +: 2] = active_high ? lcd_lvl_low : lcd_lvl_high; // [R11]
      end else begin
        next_segment_level[2*k +: 2] = active_high ? lcd_lvl_upper_mid : lcd_lvl_lower_mid;
      end
    end
  end

  // outputs straight from flops, one pclk behind the scan state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_level <= '0;
      segment_level <= '0;
    end else begin
      common_level <= next_common_level;
      segment_level <= next_segment_level; // [R4]
    end
  end

  // checks

  sequence s_copy_first;
    strobe_level && select_mask[0];
  endsequence

  property p_copy_first;
    @(posedge pclk) disable iff (!presetn)
    s_copy_first |=> row_latch[0] == $past(seg_word);
  endproperty
  a_copy_first: assert property (p_copy_first) else $error("selected latch not loaded"); // [R3]

  property p_unselected_hold;
    @(posedge pclk) disable iff (!presetn)
    !(strobe_level && select_mask[1]) |=> $stable(row_latch[1]);
  endproperty
  a_unselected_hold: assert property (p_unselected_hold) else $error("idle latch moved"); // [R5]

  // two far-apart lines picked in one frame must end up with the same word
  property p_multi_write;
    @(posedge pclk) disable iff (!presetn)
    (strobe_level && select_mask[1] && select_mask[4]) |=> row_latch[4] == row_latch[1];
  endproperty
  a_multi_write: assert property (p_multi_write) else $error("multi write uneven"); // [R6]

  property p_slot_step;
    @(posedge pclk) disable iff (!presetn)
    (slot_end && slot < last_slot && $stable(duty_sel)) |=> slot == $past(slot) + 3'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot did not advance"); // [R8]

  property p_slot_wrap;
    @(posedge pclk) disable iff (!presetn)
    (slot_end && slot == last_slot) |=> slot == 3'h0;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("scan did not wrap"); // [R8]

  // a slot cut short by a smaller ratio is the one move not tied to slot end
  property p_slot_span;
    @(posedge pclk) disable iff (!presetn)
    ($changed(slot) && $past(slot) <= $past(last_slot)) |->
      $past(sub_cnt) == LAST_TICK && $past(osc_tick);
  endproperty
  a_slot_span: assert property (p_slot_span) else $error("slot ended early"); // [R9]

  sequence s_low_half;
    slot == 3'h0 && phase == lcd_ph_low;
  endsequence

  property p_common_low;
    @(posedge pclk) disable iff (!presetn)
    s_low_half |=> common_level[1:0] == lcd_lvl_low && common_level[3:2] == lcd_lvl_upper_mid;
  endproperty
  a_common_low: assert property (p_common_low) else $error("common levels wrong"); // [R10]

  property p_seg_on_high;
    @(posedge pclk) disable iff (!presetn)
    (cur_row[SEGS-1] && display_on && active_high) |=> segment_level[1:0] == lcd_lvl_low;
  endproperty
  a_seg_on_high: assert property (p_seg_on_high) else $error("lit segment level wrong"); // [R11]

  property p_display_off;
    @(posedge pclk) disable iff (!presetn)
    (!display_on && !active_high) |=> segment_level[1:0] == lcd_lvl_lower_mid;
  endproperty
  a_display_off: assert property (p_display_off) else $error("segment lit while off"); // [R1]

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    apb_setup ##1 (psel && penable) |-> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

endmodule

// ===== include/lcd_pkg.sv
// types shared by the lcd driver modules
// assumes compilation before every design file
package lcd_pkg;

  // multiplex ratio selection
  typedef enum logic [1:0] {
    lcd_duty_3 = 2'b00,
    lcd_duty_4 = 2'b01,
    lcd_duty_5 = 2'b10
  } lcd_duty_t;

  // drive level code of one output, ordered by voltage
  typedef enum logic [1:0] {
    lcd_lvl_low = 2'b00,
    lcd_lvl_lower_mid = 2'b01,
    lcd_lvl_upper_mid = 2'b10,
    lcd_lvl_high = 2'b11
  } lcd_level_t;

  // half of a common slot
  typedef enum logic {
    lcd_ph_high = 1'b0,
    lcd_ph_low = 1'b1
  } lcd_phase_t;

endpackage

// ===== include/lcd_regs.svh
// register offsets, field positions, reset values and timing counts of the lcd driver
// assumes inclusion by bare name from the design files; definitions only
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH

// apb register byte offsets
`define LCD_CTRL_OFS 12'h000
`define LCD_STATUS_OFS 12'h004
`define LCD_OSCDIV_OFS 12'h008
`define LCD_ADDR_BITS 12

// control register: multiplex ratio field
`define LCD_CTRL_DUTY_LSB 0
`define LCD_CTRL_DUTY_RST 2'b10

// status register field positions
`define LCD_STAT_SLOT_LSB 0
`define LCD_STAT_PHASE_BIT 3
`define LCD_STAT_STROBE_BIT 4
`define LCD_STAT_DISPON_BIT 5

// serial frame layout
`define LCD_FRAME_BITS 88
`define LCD_SEG_BITS 80
`define LCD_SEL_BITS 5
`define LCD_DUMMY_BITS 3
`define LCD_KEEP_BITS 85

// scan timing, in oscillator ticks per common slot
`define LCD_SLOT_TICKS 16
`define LCD_HALF_TICKS 8

// oscillator period in nanoseconds, and the pclk divider derived from it
`define LCD_OSC_PERIOD_NS 50000
`define LCD_PCLK_PERIOD_NS 5
`define LCD_OSC_DIV_RST (`LCD_OSC_PERIOD_NS / `LCD_PCLK_PERIOD_NS)
`define LCD_OSC_DIV_MIN 2

`endif

// ===== tb/lcd_host_model.sv
// host model: serial frame loader and blanking pin
// assumes the bench calls its tasks; link clock runs only inside frames
`timescale 1ns/10ps
module lcd_host_model (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe,
  output logic display_off_n
);
  // power-up state: display kept blank until a frame is latched
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b0;
    display_off_n = 1'b0;
  end

  // blanking pin level; the bench raises it only after the first latch
  task automatic set_display(input logic on);
    display_off_n = on;
  endtask

  // 64 ns link clock: data first, then select, then dummy bits
  task automatic send_frame(input logic [79:0] seg, input logic [4:0] sel,
                            input logic [2:0] dmy);
    logic [87:0] f;
    f = {dmy, sel, seg};
    for (int i = 0; i < 88; i++) begin
      serial_data = f[i];
      #32 serial_clk = 1'b1;
      #32 serial_clk = 1'b0;
    end
    serial_data = ~f[87]; // no stale bit left on the line
    #100 latch_strobe = 1'b1; // clock stopped while strobe high
    #200 latch_strobe = 1'b0;
    #100;
  endtask
endmodule

// ===== tb/lcd_top_bench.sv
// self-checking bench for the lcd driver core
// assumes lcd_pkg compiled first and the host model beside it
`timescale 1ns/10ps
`include "lcd_regs.svh"
module lcd_top_bench import lcd_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic serial_clk, serial_data, latch_strobe, display_off_n;
  logic [9:0] common_level;
  logic [159:0] segment_level;
  logic [79:0] lat [5];
  int num_errors = 0;
  int checks_done = 0;
  int n1, n2;

  // small divider keeps a slot at 64 pclk cycles
  lcd_top #(.OSC_DIV_RESET(4)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk),
    .serial_data(serial_data), .latch_strobe(latch_strobe),
    .display_off_n(display_off_n), .common_level(common_level),
    .segment_level(segment_level));
  lcd_host_model host (.serial_clk(serial_clk), .serial_data(serial_data),
    .latch_strobe(latch_strobe), .display_off_n(display_off_n));

  // 200 mhz bus clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, then an idle cycle so no signal is driven twice at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      num_errors++;
      final_report();
    end
    @(posedge pclk);
  endtask

  function automatic logic [159:0] seg_exp(input logic [79:0] d, input logic lo);
    logic [159:0] v;
    for (int i = 0; i < 80; i++)
      v[2*i+:2] = d[i] ? (lo ? lcd_lvl_high : lcd_lvl_low)
                       : (lo ? lcd_lvl_lower_mid : lcd_lvl_upper_mid);
    return v;
  endfunction

  function automatic logic [9:0] com_exp(input int k, input logic lo);
    logic [9:0] v;
    for (int i = 0; i < 5; i++)
      v[2*i+:2] = (i == k) ? (lo ? lcd_lvl_low : lcd_lvl_high)
                           : (lo ? lcd_lvl_upper_mid : lcd_lvl_lower_mid);
    return v;
  endfunction

  // bounded wait for line k in the given half; returns edges waited
  task automatic wait_com(input int k, input logic lo, output int n);
    n = 0;
    while (common_level[2*k+:2] !== (lo ? lcd_lvl_low : lcd_lvl_high) && n < 5000) begin
      n++;
      @(posedge pclk);
    end
    if (n == 5000) begin
      num_errors++;
      final_report();
    end
  endtask

  // both halves of every line's slot against the latch image
  task automatic scan_check(input logic on);
    for (int k = 0; k < 5; k++) begin
      for (int lo = 0; lo < 2; lo++) begin
        wait_com(k, lo[0], n1);
        check("common", common_level, com_exp(k, lo[0]));
        check("segment", segment_level, seg_exp(on ? lat[k] : 80'h0, lo[0]));
      end
    end
  endtask

  task automatic t_regs();
    apb(1'b0, `LCD_CTRL_OFS, 32'h0);
    check("ctrl reset", rd, 32'h2);
    apb(1'b1, `LCD_CTRL_OFS, 32'h3);
    apb(1'b0, `LCD_CTRL_OFS, 32'h0);
    check("ctrl bad duty", rd, 32'h2);
    apb(1'b1, `LCD_OSCDIV_OFS, 32'h1);
    apb(1'b0, `LCD_OSCDIV_OFS, 32'h0);
    check("oscdiv", rd, 32'h4);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped", {err, rd}, 33'h100000000);
  endtask

  // single and multiple selects with varied dummy bits
  task automatic t_frames();
    foreach (lat[i]) lat[i] = 80'h0;
    host.send_frame(80'h0123456789abcdef0f1e, 5'h01, 3'h7);
    lat[0] = 80'h0123456789abcdef0f1e;
    host.send_frame(80'hfedcba98765432108001, 5'h16, 3'h2);
    lat[1] = 80'hfedcba98765432108001;
    lat[2] = lat[1];
    lat[4] = lat[1];
    host.send_frame(80'haaaa5555ffff0000c3c3, 5'h08, 3'h5);
    lat[3] = 80'haaaa5555ffff0000c3c3;
    host.set_display(1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, `LCD_STATUS_OFS, 32'h0);
    check("display on", rd[5:4], 2'b10);
    scan_check(1'b1);
  endtask

  // slot length and lines left unscanned for every ratio
  task automatic t_duty();
    for (int d = 0; d < 3; d++) begin
      apb(1'b1, `LCD_CTRL_OFS, d);
      apb(1'b0, `LCD_CTRL_OFS, 32'h0);
      check("ctrl duty", rd, d);
      wait_com(0, 1'b1, n1);
      wait_com(0, 1'b0, n1);
      check("idle lines", common_level, com_exp(0, 1'b0));
      wait_com(0, 1'b1, n1);
      wait_com(0, 1'b0, n2);
      check("frame cycles", n1 + n2, (d + 3) * 16 * 4);
      check("half slot", n1, `LCD_HALF_TICKS * 4);
      // the first line beyond the ratio must sit at a mid level for a whole frame
      if (d < 2) begin
        n2 = 0;
        for (int c = 0; c < (d + 3) * 64; c++) begin
          @(posedge pclk);
          if (common_level[2*(d+3)+:2] !== lcd_lvl_lower_mid &&
              common_level[2*(d+3)+:2] !== lcd_lvl_upper_mid) begin
            n2++;
          end
        end
        check("unscanned line", n2, 0);
      end
    end
  endtask

  task automatic t_blank();
    host.set_display(1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, `LCD_STATUS_OFS, 32'h0);
    check("display flag", rd[5], 1'b0);
    scan_check(1'b0);
    host.set_display(1'b1);
  endtask

  // reset, then the scenarios in order
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_frames();
    t_duty();
    t_blank();
    final_report();
  end
endmodule
